/* File: hw/sse_supervisor.sv */
`timescale 1ns/1ps
`default_nettype none
module sse_supervisor
   import sse_pkg::*;
#(
   parameter int LED_ON_CYC = FLASH_ON_CYC,
   parameter int LED_OFF_CYC = FLASH_OFF_CYC,
   parameter int LED_BLINK_CYC = BLINK_CYC
) (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   // Avalon-MM slave
   input wire logic [15:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [3:0] AVS_BYTEENABLE,
   input wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   // Synchronisation pins
   input wire logic DC_SYNC_PULSE,
   input wire logic OUTPUT_BUFFER_EVENT,
   input wire logic SYNC_HANDLED,
   input wire logic SYNC_DONE,
   // Outputs
   output logic IRQ,
   output logic ERR_LED,
   output logic [1:0] SLV_STATE
);
   // Pin synchronisers
   logic [3:0] pin_s1_ff;
   logic [3:0] pin_s2_ff;
   logic [1:0] pin_d_ff;

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         pin_s1_ff <= 4'h0;
         pin_s2_ff <= 4'h0;
         pin_d_ff <= 2'h0;
      end else begin
         pin_s1_ff <= {SYNC_DONE, SYNC_HANDLED, OUTPUT_BUFFER_EVENT, DC_SYNC_PULSE};
         pin_s2_ff <= pin_s1_ff;
         pin_d_ff <= pin_s2_ff[1:0];
      end
   end

   logic dc_rise;
   logic ev_rise;
   logic handled;
   logic sync_done;
   assign dc_rise = pin_s2_ff[0] & ~pin_d_ff[0];
   assign ev_rise = pin_s2_ff[1] & ~pin_d_ff[1];
   assign handled = pin_s2_ff[2];
   assign sync_done = pin_s2_ff[3];

   // Registers
   logic [31:0] sync_pulse_cycle_time_ff;
   logic [15:0] max_consecutive_comm_errors_ff;
   logic [15:0] comm_extended_setup_seven_ff;
   logic [31:0] output_sync_cycle_ff;
   sse_mode_t mode_ff;
   logic [IRQ_W-1:0] irq_mask_ff;
   sse_alarm_t irq_stat_ff;
   sse_alarm_t alarm_ff;
   logic [15:0] al_code_ff;
   sse_slv_state_t state_ff;
   logic [MISS_W-1:0] miss_cnt_ff;
   logic pending_ff;
   logic ack_ff;
   logic [31:0] rdata_ff;

   // Bus handshake, one wait cycle per access
   logic req;
   logic wr_go;
   logic [13:0] idx;
   assign req = AVS_READ | AVS_WRITE;
   assign idx = AVS_ADDRESS[15:2];
   assign wr_go = AVS_WRITE & ack_ff;
   assign AVS_WAITREQUEST = req & ~ack_ff;

   function automatic logic [31:0] merge32(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] be);
      for (int i = 0; i < 4; i++) begin
         old[i*8 +: 8] = be[i] ? d[i*8 +: 8] : old[i*8 +: 8];
      end
      merge32 = old;
   endfunction

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= req & ~ack_ff;
      end
   end

   // Control decode
   logic ctrl_wr;
   logic clear_req;
   logic trans_go;
   sse_slv_state_t trans_to;
   assign ctrl_wr = wr_go && idx == IDX_CTRL && AVS_BYTEENABLE[0];
   assign clear_req = ctrl_wr & AVS_WRITEDATA[CTRL_CLEAR];
   assign trans_go = ctrl_wr & AVS_WRITEDATA[CTRL_REQ_GO];
   assign trans_to = sse_slv_state_t'(AVS_WRITEDATA[CTRL_REQ_LSB +: 2]);

   // Configuration writes
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         sync_pulse_cycle_time_ff <= CYCLE_RST;
         max_consecutive_comm_errors_ff <= PARAM_RST;
         comm_extended_setup_seven_ff <= PARAM_RST;
         output_sync_cycle_ff <= CYCLE_RST;
         mode_ff <= MODE_FREE_RUN;
         irq_mask_ff <= '0;
      end else if (wr_go) begin
         unique case (idx)
            IDX_SYNC_PULSE_CYCLE: begin
               sync_pulse_cycle_time_ff <= merge32(sync_pulse_cycle_time_ff, AVS_WRITEDATA,
                                                   AVS_BYTEENABLE);
            end
            IDX_MAX_CONSEC: begin
               max_consecutive_comm_errors_ff <= 16'(merge32(
                  {16'h0000, max_consecutive_comm_errors_ff}, AVS_WRITEDATA, AVS_BYTEENABLE));
            end
            IDX_EXT_SETUP7: begin
               comm_extended_setup_seven_ff <= 16'(merge32(
                  {16'h0000, comm_extended_setup_seven_ff}, AVS_WRITEDATA, AVS_BYTEENABLE));
            end
            IDX_OUT_SYNC_CYCLE: begin
               output_sync_cycle_ff <= merge32(output_sync_cycle_ff, AVS_WRITEDATA,
                                               AVS_BYTEENABLE);
            end
            IDX_CTRL: begin
               if (AVS_BYTEENABLE[0]) begin
                  mode_ff <= sse_mode_t'(AVS_WRITEDATA[CTRL_MODE_LSB +: 2]);
               end
            end
            IDX_IRQ_MASK: begin
               if (AVS_BYTEENABLE[0]) begin
                  irq_mask_ff <= AVS_WRITEDATA[IRQ_W-1:0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Missed interrupt supervision
   logic sync_mode;
   logic check_state;
   logic irq_in;
   logic miss;
   logic sig_evt;
   logic [MISS_W-1:0] thr;
   assign sync_mode = (mode_ff == MODE_DISTRIBUTED_CLOCK) ||
                      (mode_ff == MODE_OUTPUT_BUFFER_EVENT);
   assign check_state = (state_ff == SLV_OPERATIONAL) ||
                        (state_ff == SLV_SAFE_OPERATIONAL &&
                         !comm_extended_setup_seven_ff[EXT7_CHECK_OPER_ONLY]);
   assign irq_in = (mode_ff == MODE_DISTRIBUTED_CLOCK) ? dc_rise : ev_rise;
   assign thr = MISS_W'(max_consecutive_comm_errors_ff[THR_LSB +: THR_W]);
   assign miss = sync_mode && sync_done && irq_in && pending_ff && !handled;
   assign sig_evt = miss && check_state && (miss_cnt_ff >= thr);

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         pending_ff <= 1'b0;
         miss_cnt_ff <= '0;
      end else if (!sync_mode || !sync_done) begin
         pending_ff <= 1'b0;
         miss_cnt_ff <= '0;
      end else begin
         pending_ff <= irq_in | (pending_ff & ~handled);
         if (handled || sig_evt) begin
            miss_cnt_ff <= '0;
         end else if (miss && miss_cnt_ff != '1) begin
            miss_cnt_ff <= miss_cnt_ff + MISS_W'(1);
         end
      end
   end

   // Cycle checks on the safe-operational request
   logic to_safe;
   logic cyc_bad;
   logic cyc_evt;
   assign to_safe = trans_go && state_ff == SLV_PRE_OPERATIONAL &&
                    trans_to == SLV_SAFE_OPERATIONAL;
   always_comb begin
      unique case (mode_ff)
         MODE_DISTRIBUTED_CLOCK: begin
            cyc_bad = !sse_cycle_ok(sync_pulse_cycle_time_ff) ||
                      !sse_cycle_ok(output_sync_cycle_ff) ||
                      (sync_pulse_cycle_time_ff != output_sync_cycle_ff);
         end
         MODE_OUTPUT_BUFFER_EVENT: begin
            cyc_bad = !sse_cycle_ok(output_sync_cycle_ff);
         end
         default: begin
            cyc_bad = 1'b0;
         end
      endcase
   end
   assign cyc_evt = to_safe & cyc_bad;

   // Slave state machine
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         state_ff <= SLV_INIT;
      end else if (sig_evt) begin
         state_ff <= SLV_SAFE_OPERATIONAL;
      end else if (cyc_evt) begin
         state_ff <= SLV_PRE_OPERATIONAL;
      end else if (trans_go) begin
         state_ff <= trans_to;
      end
   end

   // Alarms and status code, set wins over clear
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         alarm_ff <= '0;
         al_code_ff <= AL_NONE;
      end else begin
         alarm_ff.sig_err <= sig_evt | (alarm_ff.sig_err & ~clear_req);
         alarm_ff.cyc_err <= cyc_evt | (alarm_ff.cyc_err & ~clear_req);
         if (sig_evt) begin
            al_code_ff <= AL_SYNC_SIGNAL;
         end else if (cyc_evt) begin
            al_code_ff <= AL_SYNC_CYCLE;
         end else if (clear_req) begin
            al_code_ff <= AL_NONE;
         end
      end
   end

   // Interrupt status, write one to clear
   logic [IRQ_W-1:0] w1c;
   assign w1c = (wr_go && idx == IDX_IRQ_STAT && AVS_BYTEENABLE[0]) ?
                AVS_WRITEDATA[IRQ_W-1:0] : '0;

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         irq_stat_ff <= '0;
      end else begin
         irq_stat_ff.sig_err <= sig_evt | (irq_stat_ff.sig_err & ~w1c[IRQ_SIG]);
         irq_stat_ff.cyc_err <= cyc_evt | (irq_stat_ff.cyc_err & ~w1c[IRQ_CYC]);
      end
   end
   assign IRQ = |(irq_stat_ff & irq_mask_ff);

   // Read data
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         rdata_ff <= 32'h0000_0000;
      end else if (AVS_READ && !ack_ff) begin
         unique case (idx)
            IDX_SYNC_PULSE_CYCLE: rdata_ff <= sync_pulse_cycle_time_ff;
            IDX_MAX_CONSEC: rdata_ff <= {16'h0000, max_consecutive_comm_errors_ff};
            IDX_EXT_SETUP7: rdata_ff <= {16'h0000, comm_extended_setup_seven_ff};
            IDX_OUT_SYNC_CYCLE: rdata_ff <= output_sync_cycle_ff;
            IDX_CTRL: rdata_ff <= {30'h0000_0000, mode_ff};
            IDX_STATUS: begin
               rdata_ff <= 32'h0000_0000;
               rdata_ff[ST_STATE_LSB +: 2] <= state_ff;
               rdata_ff[ST_SIG_ALM] <= alarm_ff.sig_err;
               rdata_ff[ST_CYC_ALM] <= alarm_ff.cyc_err;
               rdata_ff[ST_MISS_LSB +: MISS_W] <= miss_cnt_ff;
            end
            IDX_AL_CODE: rdata_ff <= {16'h0000, al_code_ff};
            IDX_IRQ_STAT: rdata_ff <= {30'h0000_0000, irq_stat_ff};
            IDX_IRQ_MASK: rdata_ff <= {30'h0000_0000, irq_mask_ff};
            default: rdata_ff <= 32'h0000_0000;
         endcase
      end
   end
   assign AVS_READDATA = rdata_ff;
   assign SLV_STATE = state_ff;

   // Error indicator
   sse_led_t led_pat;
   always_comb begin
      if (alarm_ff.sig_err) begin
         led_pat = LED_SINGLE_FLASH;
      end else if (alarm_ff.cyc_err) begin
         led_pat = LED_BLINKING;
      end else begin
         led_pat = LED_OFF;
      end
   end

   sse_indicator #(
      .ON_CYC(LED_ON_CYC),
      .OFF_CYC(LED_OFF_CYC),
      .BLK_CYC(LED_BLINK_CYC)
   ) u_indicator (
      .clk(REF_CLK),
      .rst(SYS_RST),
      .pattern(led_pat),
      .led(ERR_LED)
   );

   // Checks
   AST_THRESHOLD: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      sig_evt |-> miss && miss_cnt_ff >= thr && miss_cnt_ff != '0 || thr == '0)
      else $error("Signal error raised below threshold");

   AST_CHECK_STATE: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      sig_evt |-> state_ff == SLV_OPERATIONAL ||
         (state_ff == SLV_SAFE_OPERATIONAL &&
          !comm_extended_setup_seven_ff[EXT7_CHECK_OPER_ONLY]))
      else $error("Signal error in a state that is not checked");

   AST_MODE_GATE: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      (sig_evt |-> mode_ff != MODE_FREE_RUN) and
      (cyc_evt |-> mode_ff != MODE_FREE_RUN))
      else $error("Sync check acted in free run mode");

   AST_SIG_DROP: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      sig_evt |=> state_ff == SLV_SAFE_OPERATIONAL && al_code_ff == AL_SYNC_SIGNAL &&
         alarm_ff.sig_err)
      else $error("Signal error did not drop to safe state with code");

   AST_CYC_STAY: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      cyc_evt |=> state_ff == SLV_PRE_OPERATIONAL && al_code_ff == AL_SYNC_CYCLE ##1
         state_ff == SLV_PRE_OPERATIONAL || trans_go || sig_evt)
      else $error("Cycle error left pre-operational or wrong code");

   AST_LED_PATTERN: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      (alarm_ff.sig_err |-> led_pat == LED_SINGLE_FLASH) and
      (!alarm_ff.sig_err && alarm_ff.cyc_err |-> led_pat == LED_BLINKING))
      else $error("Indicator pattern does not match alarm");

   AST_CLEAR: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      clear_req && !sig_evt && !cyc_evt |=> alarm_ff == '0 && al_code_ff == AL_NONE)
      else $error("Clear request did not clear alarms");

   AST_DC_MATCH: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      to_safe && mode_ff == MODE_DISTRIBUTED_CLOCK &&
         sync_pulse_cycle_time_ff != output_sync_cycle_ff |-> cyc_evt ##1
         state_ff == SLV_PRE_OPERATIONAL)
      else $error("Mismatched cycle times passed the check");

   AST_DC_GOOD: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      to_safe && mode_ff == MODE_DISTRIBUTED_CLOCK && sse_cycle_ok(output_sync_cycle_ff) &&
         sync_pulse_cycle_time_ff == output_sync_cycle_ff |=> state_ff == SLV_SAFE_OPERATIONAL)
      else $error("Supported clock cycle was refused");

   AST_EVENT_BAD: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      to_safe && mode_ff == MODE_OUTPUT_BUFFER_EVENT && !sse_cycle_ok(output_sync_cycle_ff)
         |-> cyc_evt)
      else $error("Unsupported event cycle passed the check");

   AST_CHECK_WHEN: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      cyc_evt |-> trans_go && $past(state_ff) == state_ff &&
         state_ff == SLV_PRE_OPERATIONAL)
      else $error("Cycle check outside the safe-operational request");

   AST_MISS_RESET: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      handled |=> miss_cnt_ff == '0)
      else $error("Miss count kept after handled interrupt");
endmodule
`default_nettype wire

/* File: pkg/sse_pkg.sv */
package sse_pkg;
   // Register indices, byte address is four times the index
   localparam logic [13:0] IDX_SYNC_PULSE_CYCLE = 14'h09A0;
   localparam logic [13:0] IDX_MAX_CONSEC = 14'h3742;
   localparam logic [13:0] IDX_EXT_SETUP7 = 14'h37B0;
   localparam logic [13:0] IDX_OUT_SYNC_CYCLE = 14'h3800;
   localparam logic [13:0] IDX_CTRL = 14'h3801;
   localparam logic [13:0] IDX_STATUS = 14'h3802;
   localparam logic [13:0] IDX_AL_CODE = 14'h3803;
   localparam logic [13:0] IDX_IRQ_STAT = 14'h3804;
   localparam logic [13:0] IDX_IRQ_MASK = 14'h3805;
   // Field positions
   localparam int THR_LSB = 0;
   localparam int THR_W = 4;
   localparam int EXT7_CHECK_OPER_ONLY = 7;
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_REQ_LSB = 4;
   localparam int CTRL_REQ_GO = 6;
   localparam int CTRL_CLEAR = 7;
   localparam int ST_STATE_LSB = 0;
   localparam int ST_SIG_ALM = 2;
   localparam int ST_CYC_ALM = 3;
   localparam int ST_MISS_LSB = 8;
   localparam int IRQ_SIG = 0;
   localparam int IRQ_CYC = 1;
   localparam int IRQ_W = 2;
   // Codes and reset values
   localparam logic [15:0] AL_NONE = 16'h0000;
   localparam logic [15:0] AL_SYNC_SIGNAL = 16'h002C;
   localparam logic [15:0] AL_SYNC_CYCLE = 16'h0035;
   localparam logic [31:0] CYCLE_RST = 32'h0000_0000;
   localparam logic [15:0] PARAM_RST = 16'h0000;
   localparam int MISS_W = 5;
   // Indicator timing
   localparam int CLK_HZ = 10_000_000;
   localparam int FLASH_ON_MS = 200;
   localparam int FLASH_OFF_MS = 1000;
   localparam int BLINK_MS = 200;
   localparam int FLASH_ON_CYC = FLASH_ON_MS * (CLK_HZ / 1000);
   localparam int FLASH_OFF_CYC = FLASH_OFF_MS * (CLK_HZ / 1000);
   localparam int BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);

   typedef enum logic [1:0] {
      MODE_FREE_RUN,
      MODE_DISTRIBUTED_CLOCK,
      MODE_OUTPUT_BUFFER_EVENT,
      MODE_RESERVED
   } sse_mode_t;

   typedef enum logic [1:0] {
      SLV_INIT,
      SLV_PRE_OPERATIONAL,
      SLV_SAFE_OPERATIONAL,
      SLV_OPERATIONAL
   } sse_slv_state_t;

   typedef enum logic [1:0] {
      LED_OFF,
      LED_SINGLE_FLASH,
      LED_BLINKING
   } sse_led_t;

   typedef struct packed {
      logic cyc_err;
      logic sig_err;
   } sse_alarm_t;

   // Cycle time in ns is one of the eight supported periods
   function automatic logic sse_cycle_ok(input logic [31:0] ns);
      sse_cycle_ok = (ns == 32'd125000) || (ns == 32'd250000) || (ns == 32'd500000) ||
                     (ns == 32'd1000000) || (ns == 32'd2000000) || (ns == 32'd4000000) ||
                     (ns == 32'd8000000) || (ns == 32'd10000000);
   endfunction
endpackage

/* File: hw/sse_indicator.sv */
`timescale 1ns/1ps
`default_nettype none
module sse_indicator
   import sse_pkg::*;
#(
   parameter int ON_CYC = FLASH_ON_CYC,
   parameter int OFF_CYC = FLASH_OFF_CYC,
   parameter int BLK_CYC = BLINK_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Pattern select
   input wire sse_led_t pattern,
   // Indicator drive
   output logic led
);
   logic [31:0] cnt_ff;
   logic led_ff;
   sse_led_t pat_ff;
   logic [31:0] span;

   always_comb begin
      if (pattern == LED_SINGLE_FLASH) begin
         span = led_ff ? 32'(ON_CYC) : 32'(OFF_CYC);
      end else begin
         span = 32'(BLK_CYC);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_ff <= 32'h0000_0000;
         led_ff <= 1'b0;
         pat_ff <= LED_OFF;
      end else begin
         pat_ff <= pattern;
         if (pattern == LED_OFF || pattern != pat_ff) begin
            cnt_ff <= 32'h0000_0000;
            led_ff <= (pattern != LED_OFF);
         end else if (cnt_ff + 32'h0000_0001 >= span) begin
            cnt_ff <= 32'h0000_0000;
            led_ff <= ~led_ff;
         end else begin
            cnt_ff <= cnt_ff + 32'h0000_0001;
         end
      end
   end

   assign led = led_ff;
endmodule
`default_nettype wire

/* File: verif/sse_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sse_master_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Commands from the bench
   input wire logic kick,
   input wire logic use_event,
   input wire logic ack_en,
   // Pins toward the supervisor
   output logic sync_pulse,
   output logic buf_event,
   output logic handled
);
   logic [4:0] t_ff;
   logic pulse_on;

   // One interrupt per kick, fixed spacing
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         t_ff <= 5'h00;
      end else if (kick) begin
         t_ff <= 5'h01;
      end else if (t_ff != 5'h00 && t_ff < 5'h0C) begin
         t_ff <= t_ff + 5'h01;
      end else begin
         t_ff <= 5'h00;
      end
   end

   assign pulse_on = (t_ff >= 5'h01) && (t_ff <= 5'h04);
   assign sync_pulse = pulse_on && !use_event;
   assign buf_event = pulse_on && use_event;
   // Handling follows each interrupt only while the bench enables it
   assign handled = ack_en && (t_ff >= 5'h07) && (t_ff <= 5'h0A);
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top import sse_pkg::*;;
   logic ref_clk, sys_rst, avs_read, avs_write, sync_done, kick, use_event, ack_en;
   logic avs_waitrequest, irq, err_led, dc_pulse, buf_event, handled;
   logic [15:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [1:0] slv_state;
   int n_errors, check_count, n;

   sse_supervisor #(.LED_ON_CYC(4), .LED_OFF_CYC(8), .LED_BLINK_CYC(4)) i_dut (
      .REF_CLK(ref_clk), .SYS_RST(sys_rst), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
      .AVS_WRITE(avs_write), .AVS_BYTEENABLE(4'hF), .AVS_WRITEDATA(avs_writedata),
      .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
      .DC_SYNC_PULSE(dc_pulse), .OUTPUT_BUFFER_EVENT(buf_event), .SYNC_HANDLED(handled),
      .SYNC_DONE(sync_done), .IRQ(irq), .ERR_LED(err_led), .SLV_STATE(slv_state));

   sse_master_model i_master (.clk(ref_clk), .rst(sys_rst), .kick(kick),
      .use_event(use_event), .ack_en(ack_en), .sync_pulse(dc_pulse),
      .buf_event(buf_event), .handled(handled));

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   task automatic results;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic chk_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic chk_pin(input string name, input logic [1:0] exp, input logic [1:0] got);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One Avalon transfer, held until waitrequest is sampled low at a rising edge
   task automatic bus(input logic wr, input logic [13:0] idx, input logic [31:0] wd);
      @(posedge ref_clk);
      avs_address <= {idx, 2'b00};
      avs_writedata <= wd;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge ref_clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic wr(input logic [13:0] idx, input logic [31:0] d);
      bus(1'b1, idx, d);
   endtask

   task automatic rdchk(input logic [13:0] idx, input logic [31:0] exp, input string name);
      bus(1'b0, idx, 32'h0000_0000);
      chk_reg(name, exp, rd);
   endtask

   task automatic kick_once;
      @(posedge ref_clk);
      kick <= 1'b1;
      @(posedge ref_clk);
      kick <= 1'b0;
      repeat (16) @(posedge ref_clk);
   endtask

   // High cycles of the indicator over 24 cycles
   task automatic led_cnt(output int c);
      c = 0;
      repeat (24) begin
         @(negedge ref_clk);
         if (err_led === 1'b1) c++;
      end
   endtask

   // Clear, enter pre-operational, load cycles, request safe-operational
   task automatic try_cycle(input logic [1:0] m, input logic [31:0] r, input logic [31:0] o,
                            input logic ok);
      wr(IDX_IRQ_STAT, 32'h3);
      wr(IDX_CTRL, {30'h20, m});
      wr(IDX_CTRL, {30'h14, m});
      wr(IDX_SYNC_PULSE_CYCLE, r);
      wr(IDX_OUT_SYNC_CYCLE, o);
      wr(IDX_CTRL, {30'h18, m});
      repeat (2) @(negedge ref_clk);
      chk_pin("slv_state", ok ? 2'h2 : 2'h1, slv_state);
      rdchk(IDX_AL_CODE, ok ? 32'h0 : 32'h35, "al_code");
      chk_pin("irq", {1'b0, !ok}, {1'b0, irq});
   endtask

   initial begin
      repeat (30000) @(posedge ref_clk);
      n_errors++;
      results;
   end

   initial begin
      sys_rst = 1'b1;
      {avs_read, avs_write, sync_done, kick, use_event, ack_en} = 6'h00;
      avs_address = 16'h0000;
      avs_writedata = 32'h0000_0000;
      n_errors = 0;
      check_count = 0;
      repeat (4) @(posedge ref_clk);
      sys_rst <= 1'b0;
      chk_pin("slv_state", 2'h0, slv_state);
      rdchk(IDX_STATUS, 32'h0, "status");
      wr(14'h0100, 32'hFFFF_FFFF);
      rdchk(14'h0100, 32'h0, "unmapped");
      wr(IDX_IRQ_MASK, 32'h3);
      // Cycle checks
      for (int i = 0; i < 8; i++) begin
         n = 125000 << i;
         if (i == 7) n = 10000000;
         try_cycle(2'h1, 32'(n), 32'(n), 1'b1);
      end
      try_cycle(2'h1, 32'd1000000, 32'd2000000, 1'b0);
      try_cycle(2'h1, 32'd100000, 32'd100000, 1'b0);
      try_cycle(2'h2, 32'h7, 32'd500000, 1'b1);
      try_cycle(2'h0, 32'h7, 32'h3, 1'b1);
      try_cycle(2'h2, 32'd500000, 32'h3, 1'b0);
      rdchk(IDX_STATUS, 32'h9, "status");
      led_cnt(n);
      chk_reg("led_blink", 32'd12, 32'(n));
      wr(IDX_CTRL, 32'h82);
      rdchk(IDX_AL_CODE, 32'h0, "al_code");
      rdchk(IDX_IRQ_STAT, 32'h2, "irq_stat");
      wr(IDX_IRQ_STAT, 32'h3);
      led_cnt(n);
      chk_reg("led_off", 32'd0, 32'(n));
      chk_pin("irq", 2'h0, {1'b0, irq});
      // Missed interrupts in operational state, threshold 2
      wr(IDX_MAX_CONSEC, 32'h2);
      try_cycle(2'h1, 32'd1000000, 32'd1000000, 1'b1);
      wr(IDX_CTRL, {30'h1C, 2'h1});
      sync_done <= 1'b1;
      ack_en <= 1'b1;
      repeat (5) kick_once;
      rdchk(IDX_STATUS, 32'h3, "status");
      ack_en <= 1'b0;
      repeat (3) kick_once;
      rdchk(IDX_STATUS, 32'h203, "status");
      kick_once;
      rdchk(IDX_STATUS, 32'h6, "status");
      rdchk(IDX_AL_CODE, 32'h2C, "al_code");
      chk_pin("irq", 2'h1, {1'b0, irq});
      led_cnt(n);
      chk_reg("led_flash", 32'd8, 32'(n));
      wr(IDX_CTRL, 32'h81);
      rdchk(IDX_AL_CODE, 32'h0, "al_code");
      wr(IDX_IRQ_STAT, 32'h3);
      // Safe-operational misses ignored while checking operational only
      wr(IDX_EXT_SETUP7, 32'h80);
      ack_en <= 1'b1;
      kick_once;
      ack_en <= 1'b0;
      repeat (5) kick_once;
      rdchk(IDX_STATUS, 32'h402, "status");
      wr(IDX_EXT_SETUP7, 32'h0);
      kick_once;
      rdchk(IDX_AL_CODE, 32'h2C, "al_code");
      // Event mode misses, clear alarms first
      wr(IDX_CTRL, 32'h82);
      use_event <= 1'b1;
      repeat (2) kick_once;
      rdchk(IDX_STATUS, 32'h202, "status");
      kick_once;
      rdchk(IDX_AL_CODE, 32'h2C, "al_code");
      results;
   end
endmodule
`default_nettype wire
